// ### common/flash_sec_defines.svh
/*
  Constants of the flash security and protection block: register indices, configuration field layout,
  field positions, codes and reset values. Assumes inclusion by bare name from design files.
*/
`ifndef FLASH_SEC_DEFINES_SVH
`define FLASH_SEC_DEFINES_SVH

`define FS_AXI_AW          8
`define FS_IDX_W           6
`define FS_IDX_PAGE        6'h00
`define FS_IDX_GUARD       6'h01
`define FS_IDX_TEST        6'h02
`define FS_IDX_LOCK        6'h03
`define FS_IDX_KEYLO       6'h04
`define FS_IDX_KEYHI       6'h05
`define FS_IDX_CTRL        6'h06
`define FS_IDX_CFGPGM      6'h07

`define FS_CFG_BASE        16'hFF00
`define FS_CFG_BYTES       16
`define FS_CFG_AW          4
`define FS_CFG_KEY0        4'h0
`define FS_KEY_BYTES       4'h8
`define FS_CFG_PROT        4'hD
`define FS_CFG_SEC         4'hF
`define FS_CFG_ERASED      8'hFF

`define FS_BACKDOOR_UNLOCK_ENABLE_MSB       7
`define FS_BACKDOOR_UNLOCK_ENABLE_LSB       6
`define FS_NV_MSB          5
`define FS_NV_LSB          2
`define FS_SEC_MSB         1
`define FS_SEC_LSB         0
`define FS_BACKDOOR_UNLOCK_ENABLE_ON        2'h2
`define FS_SEC_UNSEC       2'h2

`define FS_GUARD_ALL       7
`define FS_GUARD_HI_EN     6
`define FS_GUARD_HI_SZ_MSB 5
`define FS_GUARD_HI_SZ_LSB 4
`define FS_GUARD_LO_EN     3
`define FS_GUARD_LO_SZ_MSB 2
`define FS_GUARD_LO_SZ_LSB 1
`define FS_GUARD_REM_EN    0

`define FS_FIX_LO_BASE     16'h4000
`define FS_WIN_LO          16'h8000
`define FS_WIN_HI          16'hBFFF
`define FS_FIX_HI_BASE     16'hC000
`define FS_PAGE_FIX_LO     6'h3E
`define FS_PAGE_FIX_HI     6'h3F
`define FS_PAGE_RST        6'h00
`define FS_PAGE_W          6
`define FS_OFS_W           14
`define FS_PHYS_W          17

`define FS_RESP_OKAY       2'h0
`define FS_RESP_SLVERR     2'h2
`define FS_CTRL_START      0
`define FS_STAT_READY      0
`define FS_STAT_BUSY       1
`define FS_STAT_UNLOCKED   2
`define FS_STAT_FAIL       3
`define FS_CFGPGM_A_MSB    11
`define FS_CFGPGM_A_LSB    8

`endif

// ### common/flash_sec_pkg.sv
/*
  Types of the flash security and protection block: sequencer states and the state records of its modules.
  Assumes flash_sec_defines.svh is available on the include path.
*/
`include "flash_sec_defines.svh"

package flash_sec_pkg;

  typedef enum logic [4:0] {
    ST_LOADP = 5'h01,
    ST_LOADS = 5'h02,
    ST_LOADW = 5'h04,
    ST_IDLE  = 5'h08,
    ST_KEY   = 5'h10
  } seq_state_t;

  typedef struct packed {
    seq_state_t              fsm;
    logic [`FS_PAGE_W-1:0]   page;
    logic [7:0]              prot;
    logic [7:0]              sec;
    logic [63:0]             keyCand;
    logic [3:0]              keyIdx;
    logic                    keyMatch;
    logic                    unlocked;
    logic                    keyFail;
    logic                    cfgReady;
    logic                    secured;
    logic                    backdoor_unlock_enable;
    logic                    awHeld;
    logic [`FS_AXI_AW-1:0]   awAddr;
    logic                    wHeld;
    logic [31:0]             wData;
    logic [3:0]              wStrb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } top_state_t;

  typedef struct packed {
    logic [`FS_PHYS_W-1:0]   phys;
    logic                    hit;
    logic                    prot;
  } guard_state_t;

  typedef struct packed {
    logic [7:0]              rdData;
  } mem_state_t;

endpackage : flash_sec_pkg

// ### common/cfg_mem_if.sv
/*
  Port bundle between the sequencer and the configuration field store.
  Assumes one clock shared by both ends; read data follow a read enable by one cycle.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

interface cfg_mem_if;
  logic                    wrEn;
  logic [`FS_CFG_AW-1:0]   wrAddr;
  logic [7:0]              wrData;
  logic                    rdEn;
  logic [`FS_CFG_AW-1:0]   rdAddr;
  logic [7:0]              rdData;

  modport mem  (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
  modport user (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
endinterface : cfg_mem_if

// ### verilog/cfg_field_mem.sv
/*
  Store of the sixteen-byte nonvolatile configuration field with a registered read port.
  Assumes the single system clock; contents survive rst_n and start erased.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

module cfg_field_mem (
  input  wire logic  clk,
  input  wire logic  rst_n,
  cfg_mem_if.mem     bus
);
  logic [7:0]               store [`FS_CFG_BYTES] = '{default: `FS_CFG_ERASED};
  flash_sec_pkg::mem_state_t s_r;
  flash_sec_pkg::mem_state_t s_nxt;

  always_ff @(posedge clk) begin
    if (bus.wrEn) begin
      store[bus.wrAddr] <= bus.wrData;
    end
  end

  always_comb begin
    s_nxt = s_r;
    if (bus.rdEn) begin
      s_nxt.rdData = store[bus.rdAddr];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdData = s_r.rdData;
endmodule : cfg_field_mem

// ### verilog/page_guard.sv
/*
  Maps a CPU address onto the physical flash array and decides whether it lies in a protected region.
  Assumes page select and guard byte from the register file; results appear one cycle after the address.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

module page_guard #(
  parameter int NUM_PAGES   = 6,
  parameter int LOWER_UNIT  = 1024,
  parameter int HIGHER_UNIT = 2048
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [15:0]           cpuAddr,
  input  wire logic [`FS_PAGE_W-1:0] pageSel,
  input  wire logic [7:0]            guard,
  output logic [`FS_PHYS_W-1:0]      physAddr,
  output logic                       hit,
  output logic                       guarded
);
  localparam logic [`FS_PAGE_W-1:0] FIRST_PAGE  = `FS_PAGE_W'(64 - NUM_PAGES);
  localparam int                    ARRAY_BYTES = NUM_PAGES * (1 << `FS_OFS_W);

  flash_sec_pkg::guard_state_t s_r;
  flash_sec_pkg::guard_state_t s_nxt;

  always_comb begin
    logic [`FS_PAGE_W-1:0] sel;
    logic                  inMap;
    logic [`FS_PHYS_W-1:0] phys;
    logic [`FS_PHYS_W-1:0] lowTop;
    logic [`FS_PHYS_W-1:0] highBase;
    logic                  inLow;
    logic                  inHigh;
    sel      = `FS_PAGE_RST;
    inMap    = 1'b1;
    if (cpuAddr >= `FS_FIX_HI_BASE) begin
      sel = `FS_PAGE_FIX_HI;
    end else if (cpuAddr >= `FS_WIN_LO) begin
      sel = pageSel; // [R1] [R2]
    end else if (cpuAddr >= `FS_FIX_LO_BASE) begin
      sel = `FS_PAGE_FIX_LO;
    end else begin
      inMap = 1'b0;
    end
    phys     = {3'(sel - FIRST_PAGE), cpuAddr[`FS_OFS_W-1:0]}; // [R1]
    lowTop   = `FS_PHYS_W'((int'(guard[`FS_GUARD_LO_SZ_MSB:`FS_GUARD_LO_SZ_LSB]) + 1) * LOWER_UNIT);
    highBase = `FS_PHYS_W'(ARRAY_BYTES - (int'(guard[`FS_GUARD_HI_SZ_MSB:`FS_GUARD_HI_SZ_LSB]) + 1) * HIGHER_UNIT);
    inLow    = phys < lowTop;
    inHigh   = phys >= highBase;
    s_nxt.phys = phys;
    s_nxt.hit  = inMap && (sel >= FIRST_PAGE);
    // Each region is enabled on its own, so the lower area may stay open while the rest is locked.
    s_nxt.prot = s_nxt.hit && (guard[`FS_GUARD_ALL] // [R3]
               || (guard[`FS_GUARD_LO_EN] && inLow) // [R4] [R5]
               || (guard[`FS_GUARD_HI_EN] && inHigh) // [R4]
               || (guard[`FS_GUARD_REM_EN] && !inLow && !inHigh)); // [R4] [R5]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign physAddr = s_r.phys;
  assign hit      = s_r.hit;
  assign guarded  = s_r.prot;
endmodule : page_guard

// ### verilog/flash_sec_top.sv
/*
  Flash security and protection configuration: AXI4-Lite register file, load of the configuration field
  after reset, backdoor key comparison and the paged, guarded address map.
  Assumes one 20 MHz clock, synchronous active-low reset and a single-outstanding AXI4-Lite master.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

// Summary of operation
// R1: Window 0x8000-0xBFFF maps selected physical page.
// R2: Page codes 0x3E/0x3F alias fixed pages.
// R3: Guard register can protect whole array.
// R4: Lower, higher, remaining regions enable independently.
// R5: Lower open while remaining protected allowed.
// R6: Defaults and security come from config field.
// R7: Eight key bytes at 0xFF00-0xFF07 compared.
// R8: Guard default loads from byte 0xFF0D.
// R9: Lock and options load from 0xFF0F.
// R10: Backdoor enabled only when enable field is 10.
// R11: Bits 5-2 are plain user flags.
// R12: Unsecured only when lock state is 10.
// R13: Successful backdoor forces lock state to 10.
// R14: Factory test register reads zero, ignores writes.
// R15: Reset release copies config bytes into registers.
module flash_sec_top #(
  parameter int NUM_PAGES   = 6,
  parameter int LOWER_UNIT  = 1024,
  parameter int HIGHER_UNIT = 2048
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [`FS_AXI_AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [`FS_AXI_AW-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic [15:0]           cpuAddr,
  output logic [`FS_PHYS_W-1:0]      physAddr,
  output logic                       windowHit,
  output logic                       regionProtected,
  output logic                       chipSecured,
  output logic                       backdoorEnabled,
  output logic [3:0]                 userFlags,
  output logic                       configLoaded
);
  localparam flash_sec_pkg::top_state_t RST_STATE = '{
    fsm:      flash_sec_pkg::ST_LOADP,
    page:     `FS_PAGE_RST,
    prot:     `FS_CFG_ERASED,
    sec:      `FS_CFG_ERASED,
    secured:  1'b1,
    default:  '0
  };

  flash_sec_pkg::top_state_t s_r;
  flash_sec_pkg::top_state_t s_nxt;
  cfg_mem_if                 memBus ();

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  function automatic logic isMapped(input logic [`FS_IDX_W-1:0] idx);
    return idx <= `FS_IDX_CFGPGM;
  endfunction : isMapped

  always_comb begin
    logic                  awFire;
    logic                  wFire;
    logic                  arFire;
    logic [`FS_IDX_W-1:0]  wIdx;
    logic [`FS_IDX_W-1:0]  rIdx;
    logic [31:0]           merged;
    logic [2:0]            cmpIdx;
    logic                  match;
    awFire = awvalid && s_r.awready;
    wFire  = wvalid && s_r.wready;
    arFire = arvalid && s_r.arready;
    wIdx   = '0;
    rIdx   = araddr[`FS_AXI_AW-1:2];
    merged = '0;
    cmpIdx = '0;
    match  = 1'b0;
    s_nxt  = s_r;
    memBus.wrEn   = 1'b0;
    memBus.wrAddr = '0;
    memBus.wrData = '0;
    memBus.rdEn   = 1'b0;
    memBus.rdAddr = '0;

    unique case (s_r.fsm)
      flash_sec_pkg::ST_LOADP: begin
        memBus.rdEn   = 1'b1; // [R6] [R15]
        memBus.rdAddr = `FS_CFG_PROT; // [R8]
        s_nxt.fsm     = flash_sec_pkg::ST_LOADS;
      end
      flash_sec_pkg::ST_LOADS: begin
        s_nxt.prot    = memBus.rdData; // [R8] [R15]
        memBus.rdEn   = 1'b1;
        memBus.rdAddr = `FS_CFG_SEC; // [R9]
        s_nxt.fsm     = flash_sec_pkg::ST_LOADW;
      end
      flash_sec_pkg::ST_LOADW: begin
        s_nxt.sec      = memBus.rdData; // [R9] [R15]
        s_nxt.cfgReady = 1'b1;
        s_nxt.fsm      = flash_sec_pkg::ST_IDLE;
      end
      flash_sec_pkg::ST_IDLE: begin
      end
      flash_sec_pkg::ST_KEY: begin
        // Read data lag the address by one cycle, so byte k is checked while byte k+1 is fetched.
        if (s_r.keyIdx < `FS_KEY_BYTES) begin
          memBus.rdEn   = 1'b1;
          memBus.rdAddr = `FS_CFG_KEY0 + s_r.keyIdx; // [R7]
        end
        if (s_r.keyIdx != '0) begin
          cmpIdx = 3'(s_r.keyIdx - 4'h1);
          match  = s_r.keyMatch && (memBus.rdData == s_r.keyCand[{cmpIdx, 3'b000} +: 8]); // [R7]
          s_nxt.keyMatch = match;
        end
        if (s_r.keyIdx == `FS_KEY_BYTES) begin
          s_nxt.fsm = flash_sec_pkg::ST_IDLE;
          if (match && s_r.backdoor_unlock_enable) begin // [R10]
            s_nxt.unlocked = 1'b1;
            s_nxt.sec[`FS_SEC_MSB:`FS_SEC_LSB] = `FS_SEC_UNSEC; // [R13]
          end else begin
            s_nxt.keyFail = 1'b1;
          end
        end else begin
          s_nxt.keyIdx = s_r.keyIdx + 4'h1;
        end
      end
    endcase

    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (awFire) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wFire) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_nxt.awHeld && s_nxt.wHeld && !s_nxt.bvalid) begin
      wIdx         = s_nxt.awAddr[`FS_AXI_AW-1:2];
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = isMapped(wIdx) ? `FS_RESP_OKAY : `FS_RESP_SLVERR;
      merged       = laneMerge(32'h0000_0000, s_nxt.wData, s_nxt.wStrb);
      unique case (wIdx)
        `FS_IDX_PAGE: begin
          if (s_nxt.wStrb[0]) begin
            s_nxt.page = merged[`FS_PAGE_W-1:0]; // [R1] [R2]
          end
        end
        `FS_IDX_GUARD: begin
          if (s_nxt.wStrb[0]) begin
            s_nxt.prot = merged[7:0]; // [R3] [R4]
          end
        end
        `FS_IDX_KEYLO: begin
          s_nxt.keyCand[31:0] = laneMerge(s_r.keyCand[31:0], s_nxt.wData, s_nxt.wStrb);
        end
        `FS_IDX_KEYHI: begin
          s_nxt.keyCand[63:32] = laneMerge(s_r.keyCand[63:32], s_nxt.wData, s_nxt.wStrb);
        end
        `FS_IDX_CTRL: begin
          if (s_nxt.wStrb[0] && merged[`FS_CTRL_START] && s_r.fsm == flash_sec_pkg::ST_IDLE) begin
            s_nxt.keyFail  = !s_r.backdoor_unlock_enable; // [R10]
            s_nxt.keyMatch = 1'b1;
            s_nxt.keyIdx   = '0;
            s_nxt.fsm      = s_r.backdoor_unlock_enable ? flash_sec_pkg::ST_KEY : flash_sec_pkg::ST_IDLE;
          end
        end
        `FS_IDX_CFGPGM: begin
          memBus.wrEn   = s_nxt.wStrb[0];
          memBus.wrAddr = s_nxt.wData[`FS_CFGPGM_A_MSB:`FS_CFGPGM_A_LSB];
          memBus.wrData = s_nxt.wData[7:0];
        end
        default: begin
          // Test slot, read-only lock register and unmapped words change nothing.
        end
      endcase
    end
    s_nxt.awready = !s_nxt.awHeld && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.wHeld && !s_nxt.bvalid;

    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arFire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = isMapped(rIdx) ? `FS_RESP_OKAY : `FS_RESP_SLVERR;
      unique case (rIdx)
        `FS_IDX_PAGE:   s_nxt.rdata = {{(32-`FS_PAGE_W){1'b0}}, s_r.page};
        `FS_IDX_GUARD:  s_nxt.rdata = {24'h00_0000, s_r.prot};
        `FS_IDX_TEST:   s_nxt.rdata = 32'h0000_0000; // [R14]
        `FS_IDX_LOCK:   s_nxt.rdata = {24'h00_0000, s_r.sec}; // [R11] [R13]
        `FS_IDX_KEYLO:  s_nxt.rdata = s_r.keyCand[31:0];
        `FS_IDX_KEYHI:  s_nxt.rdata = s_r.keyCand[63:32];
        `FS_IDX_CTRL: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rdata[`FS_STAT_READY]    = s_r.cfgReady;
          s_nxt.rdata[`FS_STAT_BUSY]     = s_r.fsm != flash_sec_pkg::ST_IDLE;
          s_nxt.rdata[`FS_STAT_UNLOCKED] = s_r.unlocked;
          s_nxt.rdata[`FS_STAT_FAIL]     = s_r.keyFail;
        end
        default:        s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    s_nxt.secured = s_nxt.sec[`FS_SEC_MSB:`FS_SEC_LSB] != `FS_SEC_UNSEC; // [R12]
    s_nxt.backdoor_unlock_enable   = s_nxt.sec[`FS_BACKDOOR_UNLOCK_ENABLE_MSB:`FS_BACKDOOR_UNLOCK_ENABLE_LSB] == `FS_BACKDOOR_UNLOCK_ENABLE_ON; // [R10]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  cfg_field_mem u_cfg (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (memBus.mem)
  );

  page_guard #(
    .NUM_PAGES   (NUM_PAGES),
    .LOWER_UNIT  (LOWER_UNIT),
    .HIGHER_UNIT (HIGHER_UNIT)
  ) u_guard (
    .clk      (clk),
    .rst_n    (rst_n),
    .cpuAddr  (cpuAddr),
    .pageSel  (s_r.page),
    .guard    (s_r.prot),
    .physAddr (physAddr),
    .hit      (windowHit),
    .guarded  (regionProtected)
  );

  assign awready         = s_r.awready;
  assign wready          = s_r.wready;
  assign bvalid          = s_r.bvalid;
  assign bresp           = s_r.bresp;
  assign arready         = s_r.arready;
  assign rvalid          = s_r.rvalid;
  assign rdata           = s_r.rdata;
  assign rresp           = s_r.rresp;
  assign chipSecured     = s_r.secured; // [R12]
  assign backdoorEnabled = s_r.backdoor_unlock_enable;
  assign userFlags       = s_r.sec[`FS_NV_MSB:`FS_NV_LSB]; // [R11]
  assign configLoaded    = s_r.cfgReady;
endmodule : flash_sec_top

// ### testbench/flash_sec_monitor.sv
/*
  Bus, lock-field and address-map checks on the ports of flash_sec_top, attached by bind.
  Assumes the single clock clk and the synchronous active-low reset rst_n of the block.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

module flash_sec_monitor #(
  parameter int NUM_PAGES   = 6,
  parameter int LOWER_UNIT  = 1024,
  parameter int HIGHER_UNIT = 2048
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic [1:0]            bresp,
  input wire logic                  bvalid,
  input wire logic                  bready,
  input wire logic [`FS_AXI_AW-1:0] araddr,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [31:0]           rdata,
  input wire logic [1:0]            rresp,
  input wire logic                  rvalid,
  input wire logic [15:0]           cpuAddr,
  input wire logic [`FS_PHYS_W-1:0] physAddr,
  input wire logic                  windowHit,
  input wire logic                  chipSecured,
  input wire logic                  backdoorEnabled,
  input wire logic [3:0]            userFlags,
  input wire logic                  configLoaded
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response missing");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data missing");
  a_test_zero: assert property (arvalid && arready && araddr[7:2] == `FS_IDX_TEST |=> rdata == 32'h0)
    else $error("test register not zero");
  a_unmapped_err: assert property (arvalid && arready && araddr[7:2] > 6'h07 |=> rresp == `FS_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_lock_state: assert property (arvalid && arready && araddr[7:2] == `FS_IDX_LOCK |=>
      ((rdata[1:0] != `FS_SEC_UNSEC) == $past(chipSecured)) &&
      ((rdata[7:6] == `FS_BACKDOOR_UNLOCK_ENABLE_ON) == $past(backdoorEnabled)))
    else $error("lock field and status outputs disagree");
  a_lock_flags: assert property (arvalid && arready && araddr[7:2] == `FS_IDX_LOCK |=>
      rdata[5:2] == $past(userFlags))
    else $error("user flags disagree");
  a_fixed_high: assert property (cpuAddr >= `FS_FIX_HI_BASE |=>
      windowHit && physAddr == {3'(NUM_PAGES - 1), $past(cpuAddr[13:0])})
    else $error("top fixed page map wrong");
  a_fixed_low: assert property (cpuAddr >= `FS_FIX_LO_BASE && cpuAddr < `FS_WIN_LO |=>
      windowHit && physAddr == {3'(NUM_PAGES - 2), $past(cpuAddr[13:0])})
    else $error("bottom fixed page map wrong");
  a_unlock_cause: assert property ($fell(chipSecured) |-> backdoorEnabled || $rose(configLoaded))
    else $error("unsecured without backdoor");
  a_load_time: assert property ($rose(rst_n) |-> ##[1:4] configLoaded)
    else $error("configuration not loaded");

  c_unlock: cover property ($fell(chipSecured) && backdoorEnabled);
  c_refused: cover property (rvalid && rresp == `FS_RESP_SLVERR);
  c_write: cover property (bvalid && bready);
endmodule : flash_sec_monitor

bind flash_sec_top flash_sec_monitor #(.NUM_PAGES(NUM_PAGES), .LOWER_UNIT(LOWER_UNIT), .HIGHER_UNIT(HIGHER_UNIT))
  mon (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .cpuAddr(cpuAddr), .physAddr(physAddr),
  .windowHit(windowHit), .chipSecured(chipSecured), .backdoorEnabled(backdoorEnabled),
  .userFlags(userFlags), .configLoaded(configLoaded));

// ### testbench/testbench.sv
/*
  Self-checking bench of flash_sec_top: registers over AXI4-Lite, paging, guarding and backdoor unlock.
  Assumes the configuration store keeps programmed bytes over rst_n and starts erased.
*/
`timescale 1ns/10ps
`include "flash_sec_defines.svh"

module testbench;
  logic                  clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic                  awready, wready, bvalid, arready, rvalid, windowHit, regionProtected;
  logic                  chipSecured, backdoorEnabled, configLoaded;
  logic [`FS_AXI_AW-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb, userFlags;
  logic [1:0]            bresp, rresp;
  logic [15:0]           cpuAddr;
  logic [`FS_PHYS_W-1:0] physAddr;
  int                    n_mismatch, checked;
  // Each entry: guard byte, CPU address, expected protection; page select is 0x3A.
  logic [24:0]           gTab [9] = '{{8'h80, 16'h8010, 1'b1}, {8'h80, 16'hFFF0, 1'b1}, {8'h01, 16'h8010, 1'b0},
                                      {8'h01, 16'h8800, 1'b1}, {8'h08, 16'h8010, 1'b1}, {8'h08, 16'h8800, 1'b0},
                                      {8'h40, 16'hFFF0, 1'b1}, {8'h40, 16'hF000, 1'b0}, {8'h00, 16'hFFF0, 1'b0}};

  flash_sec_top dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cpuAddr(cpuAddr), .physAddr(physAddr), .windowHit(windowHit),
    .regionProtected(regionProtected), .chipSecured(chipSecured), .backdoorEnabled(backdoorEnabled),
    .userFlags(userFlags), .configLoaded(configLoaded));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Write and read hold bready and rready high all run, so no signal is assigned twice in one step.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask : axiRead

  task automatic readCheck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(d, exp);
  endtask : readCheck

  task automatic doReset();
    int n;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 10 && configLoaded !== 1'b1; n++) @(posedge clk);
    check(configLoaded, 1'b1);
  endtask : doReset

  task automatic cfgProg(input logic [3:0] idx, input logic [7:0] b);
    logic [1:0] r;
    axiWrite(8'h1C, {20'h0, idx, b}, r);
  endtask : cfgProg

  task automatic testDefaults();
    readCheck(8'h04, 32'hFF);
    readCheck(8'h0C, 32'hFF);
    check({chipSecured, backdoorEnabled, userFlags}, 6'h2F);
    $display("test defaults done");
  endtask : testDefaults

  task automatic testRegs();
    logic [1:0] r;
    axiWrite(8'h08, 32'hFFFFFFFF, r);
    readCheck(8'h08, 32'h0);
    axiWrite(8'h20, 32'h1, r);
    check(r, `FS_RESP_SLVERR);
    $display("test registers done");
  endtask : testRegs

  task automatic testPaging();
    logic [1:0] r;
    for (int p = 8'h3A; p <= 8'h3F; p++) begin
      axiWrite(8'h00, 32'(p), r);
      cpuAddr <= 16'h9234;
      repeat (3) @(posedge clk);
      check({windowHit, physAddr}, {1'b1, 3'(p - 8'h3A), 14'h1234});
    end
    cpuAddr <= 16'h4234;
    repeat (2) @(posedge clk);
    check({windowHit, physAddr}, {1'b1, 3'h4, 14'h0234});
    cpuAddr <= 16'h2234;
    repeat (2) @(posedge clk);
    check({windowHit, regionProtected}, 2'b00);
    $display("test paging done");
  endtask : testPaging

  task automatic testGuard();
    logic [1:0] r;
    axiWrite(8'h00, 32'h3A, r);
    foreach (gTab[i]) begin
      axiWrite(8'h04, {24'h0, gTab[i][24:17]}, r);
      cpuAddr <= gTab[i][16:1];
      repeat (3) @(posedge clk);
      check(regionProtected, gTab[i][0]);
    end
    $display("test guard done");
  endtask : testGuard

  task automatic tryKey(input logic [31:0] hi, output logic [31:0] st);
    logic [1:0] r;
    axiWrite(8'h10, 32'h13121110, r);
    axiWrite(8'h14, hi, r);
    axiWrite(8'h18, 32'h1, r);
    do begin
      axiRead(8'h18, st, r);
    end while (st[1] !== 1'b0 || st[3:2] == 2'b00);
  endtask : tryKey

  task automatic testKey();
    logic [31:0] st;
    for (int c = 0; c < 4; c++) begin
      cfgProg(4'hF, {2'(c), 4'h6, 2'(c)});
      doReset();
      check({chipSecured, backdoorEnabled, userFlags}, {c != 2, c == 2, 4'h6});
    end
    for (int i = 0; i < 8; i++) cfgProg(4'(i), 8'(8'h10 + i));
    cfgProg(4'hD, 8'h08);
    cfgProg(4'hF, 8'hA9);
    doReset();
    readCheck(8'h0C, 32'hA9);
    readCheck(8'h04, 32'h08);
    tryKey(32'h17161515, st);
    check({st[3:2], chipSecured}, 3'b101);
    tryKey(32'h17161514, st);
    check({st[3:2], chipSecured}, 3'b010);
    readCheck(8'h0C, 32'hAA);
    cfgProg(4'hF, 8'h69);
    doReset();
    tryKey(32'h17161514, st);
    check({st[3:2], chipSecured}, 3'b101);
    $display("test key done");
  endtask : testKey

  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    cpuAddr = 16'h0;
    doReset();
    testDefaults();
    testRegs();
    testPaging();
    testGuard();
    testKey();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : testbench
